// >>> usbp_pkg.sv
// Package: register map, field positions, reset values and timing of the shadow buffer port
package usbp_pkg;

  // Register byte offsets within the port's window
  localparam logic [11:0] ADDR_SHADOW_FIRST  = 12'h000;
  localparam logic [11:0] ADDR_SHADOW_LAST   = 12'h03C;
  localparam logic [11:0] ADDR_SHADOW_TWO    = 12'h008;
  localparam logic [11:0] ADDR_PRIMARY_BUF   = 12'h040;
  localparam logic [11:0] ADDR_FIFO_CTRL     = 12'h044;
  localparam logic [11:0] ADDR_LINE_STATUS   = 12'h048;
  localparam logic [11:0] ADDR_IRQ_STATUS    = 12'h04C;
  localparam logic [11:0] ADDR_IRQ_MASK      = 12'h050;
  localparam logic [11:0] ADDR_BAUD_DIV      = 12'h054;

  // Absolute address of shadow location two
  localparam logic [31:0] SHADOW_TWO_ABS     = 32'h5000_1038;

  // Field positions
  localparam int FCR_FIFO_EN_BIT    = 0;
  localparam int FCR_IR_MODE_BIT    = 1;
  localparam int FCR_RX_RESET_BIT   = 2;
  localparam int FCR_TX_RESET_BIT   = 3;
  localparam int LSR_DATA_READY_BIT = 0;
  localparam int LSR_OVERRUN_BIT    = 1;
  localparam int LSR_THR_EMPTY_BIT  = 5;
  localparam int LSR_TX_IDLE_BIT    = 6;
  localparam int IRQ_RX_BIT         = 0;
  localparam int IRQ_OVERRUN_BIT    = 1;
  localparam int IRQ_TX_EMPTY_BIT   = 2;

  // Widths and depths
  localparam int FIFO_DEPTH   = 16;
  localparam int PTR_W        = 4;
  localparam int CNT_W        = 5;
  localparam int BYTE_W       = 8;
  localparam int REG_W        = 16;

  // Reset values
  localparam logic [7:0]  FCR_RESET      = 8'h00;
  localparam logic [15:0] BAUD_DIV_RESET = 16'h0010;
  localparam logic [2:0]  IRQ_MASK_RESET = 3'h0;

  // Bit clock oversampling and serial framing
  localparam logic [3:0]  OVERSAMPLE_LAST = 4'hF;
  localparam logic [3:0]  SAMPLE_MID      = 4'h7;
  localparam logic [3:0]  DATA_BITS_LAST  = 4'h7;
  localparam logic [3:0]  IR_PULSE_TICKS  = 4'h3;

  // Line encodings for the AXI response
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage : usbp_pkg

// >>> usbp_fifo.sv
// Byte FIFO with overflow discard, used for both receive and transmit queues
`timescale 1ns/1ps
module usbp_fifo
(
  // Clock and reset
  input  wire logic                            aclk,
  input  wire logic                            aresetn,
  // Control
  input  wire logic                            flush,
  // Push side
  input  wire logic                            push,
  input  wire logic [usbp_pkg::BYTE_W-1:0]     push_data,
  // Pop side
  input  wire logic                            pop,
  output logic      [usbp_pkg::BYTE_W-1:0]     head,
  // Status
  output logic                                 full,
  output logic                                 empty
);

  typedef struct packed {
    logic [usbp_pkg::PTR_W-1:0] wr_ptr;
    logic [usbp_pkg::PTR_W-1:0] rd_ptr;
    logic [usbp_pkg::CNT_W-1:0] count;
  } usbp_fifo_s;

  usbp_fifo_s                            st;
  usbp_fifo_s                            next_st;
  logic [usbp_pkg::BYTE_W-1:0]           mem [usbp_pkg::FIFO_DEPTH];
  logic                                  do_push;
  logic                                  do_pop;

  assign full    = (st.count == usbp_pkg::CNT_W'(usbp_pkg::FIFO_DEPTH));
  assign empty   = (st.count == '0);
  assign head    = mem[st.rd_ptr];
  // A push into a full queue is dropped unless a pop frees a slot in the same cycle
  assign do_push = push && (!full || do_pop);
  assign do_pop  = pop && !empty;

  always_comb
  begin
    next_st = st;
    if (do_push)
    begin
      next_st.wr_ptr = st.wr_ptr + 1'b1;
    end
    if (do_pop)
    begin
      next_st.rd_ptr = st.rd_ptr + 1'b1;
    end
    next_st.count = st.count + usbp_pkg::CNT_W'(do_push) - usbp_pkg::CNT_W'(do_pop);
    if (flush)
    begin
      next_st = '0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (do_push)
    begin
      mem[st.wr_ptr] <= push_data;
    end
  end

endmodule : usbp_fifo

// >>> usbp_serial.sv
// Serial engine: 8N1 transmitter and receiver with plain and infrared line modes
`timescale 1ns/1ps
module usbp_serial
(
  // Clock and reset
  input  wire logic                            aclk,
  input  wire logic                            aresetn,
  // Configuration
  input  wire logic [15:0]                     baud_div,
  input  wire logic                            ir_mode,
  // Transmit request
  input  wire logic                            tx_start,
  input  wire logic [usbp_pkg::BYTE_W-1:0]     tx_byte,
  output logic                                 tx_busy,
  // Receive result
  output logic                                 rx_done,
  output logic [usbp_pkg::BYTE_W-1:0]          rx_byte,
  // Line pins
  input  wire logic                            serial_in,
  input  wire logic                            ir_in,
  output logic                                 serial_out,
  output logic                                 ir_out_n
);

  typedef enum logic [1:0] {
    USBP_IDLE  = 2'b00,
    USBP_START = 2'b01,
    USBP_DATA  = 2'b10,
    USBP_STOP  = 2'b11
  } usbp_phase_e;

  typedef struct packed {
    logic [15:0]       div_cnt;
    usbp_phase_e       tx_phase;
    logic [3:0]        tx_tick;
    logic [3:0]        tx_bit;
    logic [7:0]        tx_shift;
    logic              tx_line;
    logic              ir_pulse;
    usbp_phase_e       rx_phase;
    logic [3:0]        rx_tick;
    logic [3:0]        rx_bit;
    logic [7:0]        rx_shift;
    logic              rx_done;
  } usbp_serial_s;

  usbp_serial_s st;
  usbp_serial_s next_st;
  logic         tick;
  logic         rx_line;

  assign tick       = (st.div_cnt == '0);
  // Infrared input pulses low for a zero bit, so idle high in both modes
  assign rx_line    = ir_mode ? ir_in : serial_in;
  assign tx_busy    = (st.tx_phase != USBP_IDLE);
  assign rx_done    = st.rx_done;
  assign rx_byte    = st.rx_shift;
  assign serial_out = ir_mode ? 1'b1 : st.tx_line;
  assign ir_out_n   = ir_mode ? !st.ir_pulse : 1'b1;

  always_comb
  begin
    next_st         = st;
    next_st.rx_done = 1'b0;
    next_st.div_cnt = tick ? baud_div : st.div_cnt - 16'h0001;
    unique case (st.tx_phase)
      USBP_IDLE:
      begin
        next_st.tx_line = 1'b1;
        if (tx_start)
        begin
          next_st.tx_shift = tx_byte;
          next_st.tx_phase = USBP_START;
          next_st.tx_tick  = '0;
          next_st.tx_line  = 1'b0;
        end
      end
      USBP_START, USBP_DATA, USBP_STOP:
      begin
        if (tick)
        begin
          next_st.tx_tick = st.tx_tick + 1'b1;
          if (st.tx_tick == usbp_pkg::OVERSAMPLE_LAST)
          begin
            if (st.tx_phase == USBP_START)
            begin
              next_st.tx_phase = USBP_DATA;
              next_st.tx_bit   = '0;
              next_st.tx_line  = st.tx_shift[0];
            end
            else if (st.tx_phase == USBP_DATA)
            begin
              next_st.tx_shift = {1'b1, st.tx_shift[7:1]};
              if (st.tx_bit == usbp_pkg::DATA_BITS_LAST)
              begin
                next_st.tx_phase = USBP_STOP;
                next_st.tx_line  = 1'b1;
              end
              else
              begin
                next_st.tx_bit  = st.tx_bit + 1'b1;
                next_st.tx_line = st.tx_shift[1];
              end
            end
            else
            begin
              next_st.tx_phase = USBP_IDLE;
            end
          end
        end
      end
    endcase
    // Infrared sends a short low pulse for each zero bit
    next_st.ir_pulse = !next_st.tx_line && (next_st.tx_tick < usbp_pkg::IR_PULSE_TICKS);
    unique case (st.rx_phase)
      USBP_IDLE:
      begin
        if (!rx_line)
        begin
          next_st.rx_phase = USBP_START;
          next_st.rx_tick  = '0;
        end
      end
      USBP_START:
      begin
        if (tick)
        begin
          next_st.rx_tick = st.rx_tick + 1'b1;
          if (st.rx_tick == usbp_pkg::SAMPLE_MID)
          begin
            next_st.rx_tick  = '0;
            next_st.rx_bit   = '0;
            next_st.rx_phase = (!rx_line || ir_mode) ? USBP_DATA : USBP_IDLE;
          end
        end
      end
      USBP_DATA:
      begin
        if (tick)
        begin
          next_st.rx_tick = st.rx_tick + 1'b1;
          if (st.rx_tick == usbp_pkg::OVERSAMPLE_LAST)
          begin
            next_st.rx_shift = {rx_line, st.rx_shift[7:1]};
            next_st.rx_bit   = st.rx_bit + 1'b1;
            if (st.rx_bit == usbp_pkg::DATA_BITS_LAST)
            begin
              next_st.rx_phase = USBP_STOP;
            end
          end
        end
      end
      USBP_STOP:
      begin
        if (tick)
        begin
          next_st.rx_tick = st.rx_tick + 1'b1;
          if (st.rx_tick == usbp_pkg::OVERSAMPLE_LAST)
          begin
            next_st.rx_done  = 1'b1;
            next_st.rx_phase = USBP_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st          <= '0;
      st.tx_line  <= 1'b1;
      st.tx_phase <= USBP_IDLE;
      st.rx_phase <= USBP_IDLE;
    end
    else
    begin
      st <= next_st;
    end
  end

endmodule : usbp_serial

// >>> usbp_shadow_port.sv
// Top: AXI4-Lite register slave, receive and transmit queues behind sixteen shadow buffer aliases
// Function
// - Sixteen word-spaced aliases: read gives receive buffer, write gives transmit holding.
// - Reads return the byte from the serial or infrared input in bits 7:0.
// - Without FIFOs, a new byte overwrites an unread byte and flags overrun.
// - With FIFOs, a read returns the head of the receive FIFO.
// - Full receive FIFO keeps entries, drops the new byte, flags overrun.
// - Written bytes go out on the serial output or the active-low infrared output.
// - Without FIFOs, one write clears the transmit holding empty flag.
// - Without FIFOs, further writes before the flag sets overwrite the held byte.
// - With FIFOs, the transmit FIFO holds sixteen written bytes besides the byte being sent.
// - A write to a full transmit FIFO is discarded, queue unchanged.
`timescale 1ns/1ps
module usbp_shadow_port
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Serial line
  input  wire logic        serial_in,
  input  wire logic        ir_in,
  output logic             serial_out,
  output logic             ir_out_n,
  // Interrupt
  output logic             irq
);

  typedef struct packed {
    logic        aw_held;
    logic [11:0] aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [7:0]  fifo_ctrl;
    logic [15:0] baud_div;
    logic [2:0]  irq_mask;
    logic [2:0]  irq_status;
    logic        overrun;
    logic [7:0]  rx_hold;
    logic        rx_hold_full;
    logic [7:0]  tx_hold;
    logic        tx_hold_full;
    logic        fifo_en_d;
  } usbp_top_s;

  usbp_top_s   st;
  usbp_top_s   next_st;

  logic        fifo_en;
  logic        wr_fire;
  logic        rd_fire;
  logic        wr_is_buf;
  logic        rd_is_buf;
  logic        rx_done;
  logic [7:0]  rx_byte;
  logic        tx_busy;
  logic        tx_start;
  logic [7:0]  tx_byte;
  logic        rxq_push;
  logic        rxq_pop;
  logic [7:0]  rxq_head;
  logic        rxq_full;
  logic        rxq_empty;
  logic        txq_push;
  logic        txq_pop;
  logic [7:0]  txq_head;
  logic        txq_full;
  logic        txq_empty;
  logic        flush;
  logic        rx_flush;
  logic        tx_flush;
  logic        data_ready;
  logic        thr_empty;
  logic [7:0]  line_status;

  // Any alias or the primary buffer reaches the same buffer logic
  function automatic logic is_buffer(input logic [11:0] addr);
    is_buffer = (addr <= usbp_pkg::ADDR_SHADOW_LAST) || (addr == usbp_pkg::ADDR_PRIMARY_BUF);
  endfunction : is_buffer

  assign fifo_en   = st.fifo_ctrl[usbp_pkg::FCR_FIFO_EN_BIT];
  // Switching the FIFO mode empties both paths so old bytes never leak across modes
  assign flush     = (fifo_en != st.fifo_en_d);
  assign wr_fire   = st.aw_held && st.w_held && !st.bvalid;
  assign rd_fire   = s_axi_arvalid && s_axi_arready;
  assign wr_is_buf = wr_fire && is_buffer(st.aw_addr) && st.w_strb[0];
  assign rd_is_buf = rd_fire && is_buffer(s_axi_araddr);
  assign rx_flush  = flush || (wr_fire && st.aw_addr == usbp_pkg::ADDR_FIFO_CTRL && st.w_strb[0]
                     && st.w_data[usbp_pkg::FCR_RX_RESET_BIT]);
  assign tx_flush  = flush || (wr_fire && st.aw_addr == usbp_pkg::ADDR_FIFO_CTRL && st.w_strb[0]
                     && st.w_data[usbp_pkg::FCR_TX_RESET_BIT]);

  assign data_ready  = fifo_en ? !rxq_empty : st.rx_hold_full;
  assign thr_empty   = fifo_en ? txq_empty : !st.tx_hold_full;
  assign line_status = {1'b0, !tx_busy && thr_empty, thr_empty, 3'b000, st.overrun, data_ready};

  // Queue hookup; queues are idle in non-FIFO mode
  assign rxq_push = fifo_en && rx_done;
  assign rxq_pop  = fifo_en && rd_is_buf;
  assign txq_push = fifo_en && wr_is_buf;
  assign tx_start = !tx_busy && (fifo_en ? !txq_empty : st.tx_hold_full);
  assign tx_byte  = fifo_en ? txq_head : st.tx_hold;
  assign txq_pop  = fifo_en && tx_start;

  assign s_axi_awready = !st.aw_held;
  assign s_axi_wready  = !st.w_held;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;
  assign irq           = |(st.irq_status & st.irq_mask);

  always_comb
  begin
    next_st           = st;
    next_st.fifo_en_d = fifo_en;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_st.w_held = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready)
    begin
      next_st.bvalid = 1'b0;
    end
    if (st.rvalid && s_axi_rready)
    begin
      next_st.rvalid = 1'b0;
    end
    // Transmit side in non-FIFO mode: single holding byte
    if (!fifo_en && tx_start)
    begin
      next_st.tx_hold_full = 1'b0;
    end
    if (wr_fire)
    begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = usbp_pkg::RESP_OKAY;
      if (is_buffer(st.aw_addr))
      begin
        if (wr_is_buf && !fifo_en)
        begin
          next_st.tx_hold      = st.w_data[7:0];
          next_st.tx_hold_full = 1'b1;
        end
      end
      else if (st.aw_addr == usbp_pkg::ADDR_FIFO_CTRL)
      begin
        if (st.w_strb[0])
        begin
          next_st.fifo_ctrl = {st.w_data[7:4], 2'b00, st.w_data[1:0]};
        end
      end
      else if (st.aw_addr == usbp_pkg::ADDR_IRQ_MASK)
      begin
        if (st.w_strb[0])
        begin
          next_st.irq_mask = st.w_data[2:0];
        end
      end
      else if (st.aw_addr == usbp_pkg::ADDR_BAUD_DIV)
      begin
        if (st.w_strb[0])
        begin
          next_st.baud_div[7:0] = st.w_data[7:0];
        end
        if (st.w_strb[1])
        begin
          next_st.baud_div[15:8] = st.w_data[15:8];
        end
      end
      else if (st.aw_addr != usbp_pkg::ADDR_LINE_STATUS && st.aw_addr != usbp_pkg::ADDR_IRQ_STATUS)
      begin
        next_st.bresp = usbp_pkg::RESP_SLVERR;
      end
    end
    if (rd_fire)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = usbp_pkg::RESP_OKAY;
      next_st.rdata  = '0;
      if (is_buffer(s_axi_araddr))
      begin
        next_st.rdata[7:0] = fifo_en ? rxq_head : st.rx_hold;
        if (!fifo_en)
        begin
          next_st.rx_hold_full = 1'b0;
        end
      end
      else if (s_axi_araddr == usbp_pkg::ADDR_FIFO_CTRL)
      begin
        next_st.rdata[7:0] = st.fifo_ctrl;
      end
      else if (s_axi_araddr == usbp_pkg::ADDR_LINE_STATUS)
      begin
        next_st.rdata[7:0] = line_status;
        next_st.overrun    = 1'b0;
      end
      else if (s_axi_araddr == usbp_pkg::ADDR_IRQ_STATUS)
      begin
        next_st.rdata[2:0] = st.irq_status;
        next_st.irq_status = '0;
      end
      else if (s_axi_araddr == usbp_pkg::ADDR_IRQ_MASK)
      begin
        next_st.rdata[2:0] = st.irq_mask;
      end
      else if (s_axi_araddr == usbp_pkg::ADDR_BAUD_DIV)
      begin
        next_st.rdata[15:0] = st.baud_div;
      end
      else
      begin
        next_st.rresp = usbp_pkg::RESP_SLVERR;
      end
    end
    if (flush)
    begin
      next_st.rx_hold_full = 1'b0;
      next_st.tx_hold_full = 1'b0;
    end
    // Hardware sets come last so a clearing read never hides a fresh event
    if (rx_done)
    begin
      next_st.irq_status[usbp_pkg::IRQ_RX_BIT] = 1'b1;
      if (!fifo_en)
      begin
        next_st.rx_hold      = rx_byte;
        next_st.rx_hold_full = 1'b1;
        if (st.rx_hold_full && !rd_is_buf)
        begin
          next_st.overrun = 1'b1;
          next_st.irq_status[usbp_pkg::IRQ_OVERRUN_BIT] = 1'b1;
        end
      end
      else if (rxq_full && !rd_is_buf)
      begin
        next_st.overrun = 1'b1;
        next_st.irq_status[usbp_pkg::IRQ_OVERRUN_BIT] = 1'b1;
      end
    end
    if (tx_start)
    begin
      next_st.irq_status[usbp_pkg::IRQ_TX_EMPTY_BIT] = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st           <= '0;
      st.fifo_ctrl <= usbp_pkg::FCR_RESET;
      st.baud_div  <= usbp_pkg::BAUD_DIV_RESET;
      st.irq_mask  <= usbp_pkg::IRQ_MASK_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  usbp_fifo u_rx_fifo
  (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .flush     (rx_flush),
    .push      (rxq_push),
    .push_data (rx_byte),
    .pop       (rxq_pop),
    .head      (rxq_head),
    .full      (rxq_full),
    .empty     (rxq_empty)
  );

  usbp_fifo u_tx_fifo
  (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .flush     (tx_flush),
    .push      (txq_push),
    .push_data (st.w_data[7:0]),
    .pop       (txq_pop),
    .head      (txq_head),
    .full      (txq_full),
    .empty     (txq_empty)
  );

  usbp_serial u_serial
  (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .baud_div   (st.baud_div),
    .ir_mode    (st.fifo_ctrl[usbp_pkg::FCR_IR_MODE_BIT]),
    .tx_start   (tx_start),
    .tx_byte    (tx_byte),
    .tx_busy    (tx_busy),
    .rx_done    (rx_done),
    .rx_byte    (rx_byte),
    .serial_in  (serial_in),
    .ir_in      (ir_in),
    .serial_out (serial_out),
    .ir_out_n   (ir_out_n)
  );

endmodule : usbp_shadow_port

// >>> usbp_partner.sv
// Remote transceiver model: drives the receive pins and decodes the plain transmit pin
`timescale 1ns/1ps
module usbp_partner
(
  // Clock
  input  wire logic  aclk,
  // Lines towards the port, idle high
  output logic       serial_in = 1'b1,
  output logic       ir_in = 1'b1,
  input  wire logic  serial_out,
  input  wire logic  ir_out_n,
  // Decoded traffic
  output logic       rx_valid = 1'b0,
  output logic [7:0] rx_byte,
  output int         ir_falls = 0
);
  // One 8N1 frame at 16 clocks a bit, LSB first
  task automatic send(input logic [7:0] d, input logic ir);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      if (ir)
        ir_in <= f[i];
      else
        serial_in <= f[i];
      repeat (16) @(posedge aclk);
    end
  endtask : send

  // Mid-bit sampling on the falling clock edge stays clear of the port's updates
  always
  begin : dec
    logic [7:0] s;
    @(negedge serial_out);
    repeat (8) @(negedge aclk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (16) @(negedge aclk);
      s[i] = serial_out;
    end
    rx_byte = s;
    rx_valid = 1'b1;
    @(negedge aclk);
    rx_valid = 1'b0;
  end

  always @(negedge ir_out_n) ir_falls++;
endmodule : usbp_partner

// >>> usbp_shadow_port_asserts.sv
// Checker: bus handshakes, read data width and line pin relations of the port
`timescale 1ns/1ps
module usbp_shadow_port_asserts
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Line
  input wire logic        serial_out,
  input wire logic        ir_out_n
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_aw_taken: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("aw ready held");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("late write answer");
  chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("late read answer");
  chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("ar ready while busy");
  chk_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  chk_pins_exclusive: assert property (!serial_out |-> ir_out_n)
    else $error("both line outputs active");

  cover property (s_axi_rvalid && s_axi_rready);
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (!ir_out_n);
endmodule : usbp_shadow_port_asserts

bind usbp_shadow_port usbp_shadow_port_asserts i_chk (.*);

// >>> test_uart_shadow_buffer_port.sv
// Testbench: bus master, remote link and self-checks for the shadow buffer port
`timescale 1ns/1ps
module test_uart_shadow_buffer_port;
  logic        aclk = 1'b0, aresetn = 1'b0, irq, rx_valid;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        serial_in, ir_in, serial_out, ir_out_n;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, seed = 32'hdc2a_8c3d;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  rx_byte, b [20], tx_q [$];
  logic [17:0] rd_q [$], e;
  int          ir_falls, n, num_errors = 0, n_tests = 0;

  usbp_shadow_port i_dut (.*);
  usbp_partner i_far (.*);
  always #2 aclk = ~aclk;

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd

  task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("Checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude

  // Ready and valid are read on the falling edge, where they already hold the next rising edge's value
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
    logic ra, rw, rb;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    rb = 1'b0;
    while (!rb)
    begin
      @(negedge aclk);
      ra = s_axi_awready & s_axi_awvalid;
      rw = s_axi_wready & s_axi_wvalid;
      rb = s_axi_bvalid;
      if (rb)
        check("write resp", 18'(s_axi_bresp), 18'(r));
      @(posedge aclk);
      if (ra)
        s_axi_awvalid <= 1'b0;
      if (rw)
        s_axi_wvalid <= 1'b0;
    end
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] m, input logic [7:0] x, input logic [1:0] r = 2'h0);
    logic ra, rv;
    rd_q.push_back({r, m, x});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    rv = 1'b0;
    while (!rv)
    begin
      @(negedge aclk);
      ra = s_axi_arready & s_axi_arvalid;
      rv = s_axi_rvalid;
      @(posedge aclk);
      if (ra)
        s_axi_arvalid <= 1'b0;
    end
  endtask : rd

  task automatic irq_is(input logic v);
    @(negedge aclk);
    check("irq", irq, v);
    @(posedge aclk);
  endtask : irq_is

  always @(negedge aclk)
    if (s_axi_rvalid && s_axi_rready)
    begin
      e = rd_q.pop_front();
      check("read", {s_axi_rresp, s_axi_rdata[7:0] & e[15:8]}, {e[17:16], e[7:0]});
    end

  always @(posedge rx_valid) check("line byte", rx_byte, tx_q.pop_front());

  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(12'h048, 8'h23, 8'h20);
    rd(12'h100, 8'hff, 8'h00, 2'h2);
    wr(12'h100, 8'h00, 2'h2);
    wr(12'h054, 8'h00);
    // The divider still runs out its old count; a frame started now would be sampled a bit late
    repeat (20) @(posedge aclk);
    for (int i = 0; i < 3; i++)
    begin
      b[i] = rnd();
      i_far.send(b[i], 1'b0);
      if (i == 0)
        rd(12'h048, 8'h03, 8'h01);
      if (i == 0)
        rd(12'h008, 8'hff, b[0]);
    end
    rd(12'h048, 8'h03, 8'h03);
    rd(12'h040, 8'hff, b[2]);
    wr(12'h044, 8'h01);
    for (int i = 0; i < 17; i++)
    begin
      b[i] = rnd();
      i_far.send(b[i], 1'b0);
    end
    rd(12'h048, 8'h03, 8'h03);
    for (int i = 0; i < 16; i++)
      rd(12'(i * 4), 8'hff, b[i]);
    rd(12'h048, 8'h01, 8'h00);
    wr(12'h044, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      b[i] = rnd();
      wr(12'h008, b[i]);
    end
    rd(12'h048, 8'h20, 8'h00);
    tx_q.push_back(b[0]);
    tx_q.push_back(b[2]);
    repeat (400) @(posedge aclk);
    wr(12'h044, 8'h01);
    for (int i = 0; i < 20; i++)
    begin
      b[i] = rnd();
      wr(12'h03c, b[i]);
      if (i < 17)
        tx_q.push_back(b[i]);
    end
    repeat (3000) @(posedge aclk);
    check("tx left", 18'(tx_q.size()), 18'h0_0000);
    wr(12'h044, 8'h02);
    b[0] = rnd();
    i_far.send(b[0], 1'b1);
    rd(12'h008, 8'hff, b[0]);
    n = ir_falls;
    wr(12'h03c, 8'h55);
    repeat (200) @(posedge aclk);
    check("ir pulses", 18'(ir_falls - n), 18'h0_0005);
    wr(12'h044, 8'h00);
    i_far.send(8'h3c, 1'b0);
    irq_is(1'b0);
    wr(12'h050, 8'h01);
    irq_is(1'b1);
    rd(12'h04c, 8'h01, 8'h01);
    irq_is(1'b0);
    check("reads left", 18'(rd_q.size()), 18'h0_0000);
    conclude();
  end

  // About seven thousand three hundred cycles are needed; more than five times that means a hang
  initial
  begin
    repeat (40000) @(posedge aclk);
    num_errors++;
    conclude();
  end
endmodule : test_uart_shadow_buffer_port
